/* shared/gpio_pkg.sv */
package gpio_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;

  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFF_C_PIN = 12'h000;
  localparam logic [11:0] OFF_C_LAT = 12'h004;
  localparam logic [11:0] OFF_C_DIR = 12'h008;
  localparam logic [11:0] OFF_D_PIN = 12'h00c;
  localparam logic [11:0] OFF_D_LAT = 12'h010;
  localparam logic [11:0] OFF_D_DIR = 12'h014;
  localparam logic [11:0] OFF_SLAVE_CTRL = 12'h018;

  // Reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [7:0] RST_SLAVE_CTRL = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // Parallel slave control fields
  localparam int CTRL_IN_FULL_BIT = 7;
  localparam int CTRL_OUT_FULL_BIT = 6;
  localparam int CTRL_OVERFLOW_BIT = 5;
  localparam int CTRL_ENABLE_BIT = 4;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hf0;

  // Port C shared pin positions
  localparam int C_OSC_OUT_BIT = 0;
  localparam int C_OSC_IN_BIT = 1;
  localparam int C_CCP_BIT = 2;
  localparam int C_SSP_CLK_BIT = 3;
  localparam int C_SSP_DATA_BIT = 4;
  localparam int C_SSP_SDO_BIT = 5;
  localparam int C_USART_TX_BIT = 6;
  localparam int C_USART_RX_BIT = 7;

  // Synchroniser depth for pin readback
  localparam int SYNC_STAGES = 2;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import gpio_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin levels and their synchronised copy
  input wire logic [WIDTH-1:0] pinRaw,
  output logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // First stage feeds only the second, so metastability settles before use
  always_comb begin
    state_nxt = state_r;
    state_nxt.stage1 = pinRaw;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pinSync = state_r.stage2;

endmodule
`default_nettype wire

/* logic/dual_byte_gpio_ports.sv */
// Contract
// - Direction one: pin is input, driver off
// - Direction zero: pin driven from output latch
// - Latch reads return latch, not pin
// - Pin register reads pins, writes latch
// - Enabled peripheral forces pin direction
// - Override never changes direction register readback
// - Port C direction resets to all ones
// - Port D direction resets to all ones
// - C0/C1 shared with oscillator, timer clock
// - C2 shared with capture/compare/PWM
// - C3..C5 shared with synchronous serial port
// - C6/C7 shared with USART
// - Enable bit turns port D parallel slave
// - Parallel mode: D pin n is data n
// - Unimplemented control bits read zero
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dual_byte_gpio_ports
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port C pins
  input wire logic [PORT_W-1:0] portCIn,
  output logic [PORT_W-1:0] portCOut,
  output logic [PORT_W-1:0] portCOe,
  // Port D pins
  input wire logic [PORT_W-1:0] portDIn,
  output logic [PORT_W-1:0] portDOut,
  output logic [PORT_W-1:0] portDOe,
  // Synchronised pin levels for the shared peripherals
  output logic [PORT_W-1:0] portCPinLevel,
  output logic [PORT_W-1:0] portDPinLevel,
  // Secondary oscillator and timer clock
  input wire logic oscEnable,
  input wire logic secondaryOscOut,
  input wire logic timerExtClockEnable,
  // Capture/compare/PWM one
  input wire logic ccpEnable,
  input wire logic ccpIsOutput,
  input wire logic ccpOut,
  // Synchronous serial port
  input wire logic sspEnable,
  input wire logic sspClkOe,
  input wire logic sspClkOut,
  input wire logic sspDataOe,
  input wire logic sspDataOut,
  input wire logic sspSdoOut,
  // USART
  input wire logic usartEnable,
  input wire logic usartClkTxOe,
  input wire logic usartClkTx,
  input wire logic usartDataOe,
  input wire logic usartData,
  // Parallel slave port handshake side
  input wire logic inputBufferFullFlag,
  input wire logic outputBufferFullFlag,
  input wire logic inputOverflowFlag,
  input wire logic slaveDrive,
  input wire logic [PORT_W-1:0] slaveDataOut,
  output logic parallelSlaveEnable
);

  typedef struct packed {
    logic [7:0] port_c_output_latch;
    logic [7:0] dirC;
    logic [7:0] port_d_output_latch;
    logic [7:0] dirD;
    logic slaveMode;
    logic [7:0] cOut;
    logic [7:0] cOe;
    logic [7:0] dOut;
    logic [7:0] dOe;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
  } port_state_t;

  port_state_t state_r;
  port_state_t state_nxt;

  logic [PORT_W-1:0] pinC;
  logic [PORT_W-1:0] pinD;
  logic [PORT_W-1:0] ovrEnC;
  logic [PORT_W-1:0] ovrOeC;
  logic [PORT_W-1:0] ovrOutC;
  logic setupPhase;
  logic accessWrite;
  logic mapped;
  logic [7:0] ctrlRead;

  // Pin levels cross into the clock domain before anyone reads them
  pin_sync #(.WIDTH(PORT_W)) syncC (
    .clk(clk),
    .rst_n(rst_n),
    .pinRaw(portCIn),
    .pinSync(pinC)
  );

  pin_sync #(.WIDTH(PORT_W)) syncD (
    .clk(clk),
    .rst_n(rst_n),
    .pinRaw(portDIn),
    .pinSync(pinD)
  );

  // Peripheral overrides on port C; enable, forced direction, drive value
  always_comb begin
    ovrEnC = '0;
    ovrOeC = '0;
    ovrOutC = '0;
    // Oscillator owns both pins; a lone external clock only needs an input
    if (oscEnable) begin
      ovrEnC[C_OSC_OUT_BIT] = 1'b1;
      ovrOeC[C_OSC_OUT_BIT] = 1'b1;
      ovrOutC[C_OSC_OUT_BIT] = secondaryOscOut;
      ovrEnC[C_OSC_IN_BIT] = 1'b1;
    end else if (timerExtClockEnable) begin
      ovrEnC[C_OSC_OUT_BIT] = 1'b1;
    end
    if (ccpEnable) begin
      ovrEnC[C_CCP_BIT] = 1'b1;
      ovrOeC[C_CCP_BIT] = ccpIsOutput;
      ovrOutC[C_CCP_BIT] = ccpOut;
    end
    if (sspEnable) begin
      ovrEnC[C_SSP_CLK_BIT] = 1'b1;
      ovrOeC[C_SSP_CLK_BIT] = sspClkOe;
      ovrOutC[C_SSP_CLK_BIT] = sspClkOut;
      ovrEnC[C_SSP_DATA_BIT] = 1'b1;
      ovrOeC[C_SSP_DATA_BIT] = sspDataOe;
      ovrOutC[C_SSP_DATA_BIT] = sspDataOut;
      ovrEnC[C_SSP_SDO_BIT] = 1'b1;
      ovrOeC[C_SSP_SDO_BIT] = 1'b1;
      ovrOutC[C_SSP_SDO_BIT] = sspSdoOut;
    end
    if (usartEnable) begin
      ovrEnC[C_USART_TX_BIT] = 1'b1;
      ovrOeC[C_USART_TX_BIT] = usartClkTxOe;
      ovrOutC[C_USART_TX_BIT] = usartClkTx;
      ovrEnC[C_USART_RX_BIT] = 1'b1;
      ovrOeC[C_USART_RX_BIT] = usartDataOe;
      ovrOutC[C_USART_RX_BIT] = usartData;
    end
  end

  // Bus phase decode
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && state_r.ready && pwrite && pstrb[0];
  assign mapped = (paddr == OFF_C_PIN) || (paddr == OFF_C_LAT) ||
                  (paddr == OFF_C_DIR) || (paddr == OFF_D_PIN) ||
                  (paddr == OFF_D_LAT) || (paddr == OFF_D_DIR) ||
                  (paddr == OFF_SLAVE_CTRL);

  // Flags come from the handshake logic; low nibble is unimplemented
  always_comb begin
    ctrlRead = '0;
    ctrlRead[CTRL_IN_FULL_BIT] = inputBufferFullFlag;
    ctrlRead[CTRL_OUT_FULL_BIT] = outputBufferFullFlag;
    ctrlRead[CTRL_OVERFLOW_BIT] = inputOverflowFlag;
    ctrlRead[CTRL_ENABLE_BIT] = state_r.slaveMode;
    ctrlRead = ctrlRead & CTRL_IMPL_MASK;
  end

  // Next state: read data, register writes, then the pin drivers
  always_comb begin
    state_nxt = state_r;
    // No wait state: ready rises in the access phase, drops after it
    state_nxt.ready = setupPhase;
    state_nxt.slvErr = setupPhase && !mapped;
    if (setupPhase) begin
      if (pwrite) begin
        state_nxt.rdata = RST_RDATA;
      end else if (paddr == OFF_C_PIN) begin
        state_nxt.rdata = {24'h00_0000, pinC};
      end else if (paddr == OFF_C_LAT) begin
        state_nxt.rdata = {24'h00_0000, state_r.port_c_output_latch};
      end else if (paddr == OFF_C_DIR) begin
        state_nxt.rdata = {24'h00_0000, state_r.dirC};
      end else if (paddr == OFF_D_PIN) begin
        state_nxt.rdata = {24'h00_0000, pinD};
      end else if (paddr == OFF_D_LAT) begin
        state_nxt.rdata = {24'h00_0000, state_r.port_d_output_latch};
      end else if (paddr == OFF_D_DIR) begin
        state_nxt.rdata = {24'h00_0000, state_r.dirD};
      end else if (paddr == OFF_SLAVE_CTRL) begin
        state_nxt.rdata = {24'h00_0000, ctrlRead};
      end else begin
        state_nxt.rdata = RST_RDATA;
      end
    end
    // Writes land only at the completing edge; pin and latch share a target
    if (accessWrite) begin
      if (paddr == OFF_C_PIN || paddr == OFF_C_LAT) begin
        state_nxt.port_c_output_latch = pwdata[7:0];
      end else if (paddr == OFF_C_DIR) begin
        state_nxt.dirC = pwdata[7:0];
      end else if (paddr == OFF_D_PIN || paddr == OFF_D_LAT) begin
        state_nxt.port_d_output_latch = pwdata[7:0];
      end else if (paddr == OFF_D_DIR) begin
        state_nxt.dirD = pwdata[7:0];
      end else if (paddr == OFF_SLAVE_CTRL) begin
        state_nxt.slaveMode = pwdata[CTRL_ENABLE_BIT];
      end
    end
    // Override acts on the pin path only; dirC itself is never touched
    state_nxt.cOe = (ovrEnC & ovrOeC) | (~ovrEnC & ~state_nxt.dirC);
    state_nxt.cOut = (ovrEnC & ovrOutC) | (~ovrEnC & state_nxt.port_c_output_latch);
    // Parallel slave mode hands every D pin to the port's data path
    if (state_nxt.slaveMode) begin
      state_nxt.dOe = {PORT_W{slaveDrive}};
      state_nxt.dOut = slaveDataOut;
    end else begin
      state_nxt.dOe = ~state_nxt.dirD;
      state_nxt.dOut = state_nxt.port_d_output_latch;
    end
  end

  // State register; latches reset to zero so no pin drives garbage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r.port_c_output_latch <= RST_LAT;
      state_r.dirC <= RST_DIR;
      state_r.port_d_output_latch <= RST_LAT;
      state_r.dirD <= RST_DIR;
      state_r.slaveMode <= RST_SLAVE_CTRL[CTRL_ENABLE_BIT];
      state_r.cOut <= '0;
      state_r.cOe <= '0;
      state_r.dOut <= '0;
      state_r.dOe <= '0;
      state_r.rdata <= RST_RDATA;
      state_r.ready <= 1'b0;
      state_r.slvErr <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = state_r.rdata;
  assign pready = state_r.ready;
  assign pslverr = state_r.slvErr;
  assign portCOut = state_r.cOut;
  assign portCOe = state_r.cOe;
  assign portDOut = state_r.dOut;
  assign portDOe = state_r.dOe;
  assign portCPinLevel = pinC;
  assign portDPinLevel = pinD;
  assign parallelSlaveEnable = state_r.slaveMode;

  // Checks on the pin path and the register file
  sequence readSetup(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence writeDone(logic [11:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence

  AST_C_INPUT_HIZ: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (($past(~ovrEnC) & state_r.dirC & portCOe) == 8'h00))
    else $error("port C input pin is driven");

  AST_D_DRIVE_LATCH: assert property (
    @(posedge clk) disable iff (!rst_n)
    !state_r.slaveMode |-> (portDOe == ~state_r.dirD &&
      (((portDOut ^ state_r.port_d_output_latch) & ~state_r.dirD) == 8'h00)))
    else $error("port D output does not follow latch");

  AST_LATCH_READBACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    readSetup(OFF_C_LAT) |=> prdata == {24'h00_0000, $past(state_r.port_c_output_latch)} ##0 pready)
    else $error("latch read did not return latch");

  AST_PIN_WRITE_LATCH: assert property (
    @(posedge clk) disable iff (!rst_n)
    writeDone(OFF_D_PIN) |=> state_r.port_d_output_latch == $past(pwdata[7:0]))
    else $error("pin register write missed latch");

  AST_PIN_READ_SYNC: assert property (
    @(posedge clk) disable iff (!rst_n)
    readSetup(OFF_C_PIN) |=> prdata[7:0] == $past(pinC))
    else $error("pin read not from synchroniser");

  AST_OVERRIDE_DIR: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> (($past(ovrEnC) & (portCOe ^ $past(ovrOeC))) == 8'h00))
    else $error("peripheral override not applied");

  AST_DIR_UNTOUCHED: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(psel && penable && pwrite && paddr == OFF_C_DIR) |=> $stable(state_r.dirC))
    else $error("direction register changed without write");

  AST_DIR_RESET: assert property (
    @(posedge clk)
    !rst_n |=> state_r.dirC == RST_DIR && state_r.dirD == RST_DIR)
    else $error("direction registers not all ones after reset");

  AST_SSP_SDO: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(sspEnable) |->
      portCOe[C_SSP_SDO_BIT] && portCOut[C_SSP_SDO_BIT] == $past(sspSdoOut))
    else $error("serial data out not on pin 5");

  AST_USART_TX: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(usartEnable) |->
      portCOe[C_USART_TX_BIT] == $past(usartClkTxOe))
    else $error("USART does not own pin 6");

  AST_SLAVE_DATA: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r.slaveMode && $past(rst_n) |->
      portDOut == $past(slaveDataOut) && portDOe == {8{$past(slaveDrive)}})
    else $error("parallel data not mapped bit for bit");

  AST_CTRL_ZERO_BITS: assert property (
    @(posedge clk) disable iff (!rst_n)
    readSetup(OFF_SLAVE_CTRL) |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h00_0000)
    else $error("unimplemented control bits not zero");

  AST_SLAVE_ENABLE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    writeDone(OFF_SLAVE_CTRL) |=> parallelSlaveEnable == $past(pwdata[CTRL_ENABLE_BIT]))
    else $error("parallel slave enable not taken from write");

  AST_OSC_PINS: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(oscEnable) |->
      portCOe[C_OSC_OUT_BIT] && !portCOe[C_OSC_IN_BIT] &&
      portCOut[C_OSC_OUT_BIT] == $past(secondaryOscOut))
    else $error("oscillator does not own pins 0 and 1");

endmodule
`default_nettype wire

/* test/pin_world.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_world
  import gpio_pkg::*;
(
  // Device side
  input wire logic [PORT_W-1:0] cOut,
  input wire logic [PORT_W-1:0] cOe,
  input wire logic [PORT_W-1:0] dOut,
  input wire logic [PORT_W-1:0] dOe,
  // Outside circuitry, driving whatever the device leaves free
  input wire logic [PORT_W-1:0] extC,
  input wire logic [PORT_W-1:0] extD,
  output logic [PORT_W-1:0] cPin,
  output logic [PORT_W-1:0] dPin
);
  // Enabled driver wins; released pins follow the board (no pull resistors)
  assign cPin = (cOe & cOut) | (~cOe & extC);
  assign dPin = (dOe & dOut) | (~dOe & extD);
endmodule
`default_nettype wire

/* test/tb_dual_byte_gpio_ports.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_byte_gpio_ports
  import gpio_pkg::*;
();
  typedef struct {
    logic [11:0] wa; logic [31:0] wd; logic [3:0] st; logic [11:0] ra; logic [31:0] ex; logic er;
  } row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [PORT_W-1:0] portCIn, portCOut, portCOe, portDIn, portDOut, portDOe;
  logic [PORT_W-1:0] portCPinLevel, portDPinLevel, extC, extD, slaveDataOut;
  logic oscEnable, secondaryOscOut, timerExtClockEnable, ccpEnable, ccpIsOutput, ccpOut;
  logic sspEnable, sspClkOe, sspClkOut, sspDataOe, sspDataOut, sspSdoOut;
  logic usartEnable, usartClkTxOe, usartClkTx, usartDataOe, usartData;
  logic inputBufferFullFlag, outputBufferFullFlag, inputOverflowFlag, slaveDrive;
  logic parallelSlaveEnable;
  int n_mismatch = 0;
  int checks_done = 0;
  // Write, then read back; the last row hits an unmapped word
  row_t rows [9] = '{
    '{OFF_C_LAT, 32'h0000_00a5, 4'hf, OFF_C_LAT, 32'h0000_00a5, 1'b0},
    '{OFF_C_LAT, 32'h0000_0011, 4'he, OFF_C_LAT, 32'h0000_00a5, 1'b0},
    '{OFF_C_DIR, 32'h0000_000f, 4'hf, OFF_C_DIR, 32'h0000_000f, 1'b0},
    '{OFF_D_LAT, 32'h0000_003c, 4'hf, OFF_D_LAT, 32'h0000_003c, 1'b0},
    '{OFF_D_PIN, 32'h0000_00c3, 4'hf, OFF_D_LAT, 32'h0000_00c3, 1'b0},
    '{OFF_D_DIR, 32'h0000_00f0, 4'hf, OFF_D_DIR, 32'h0000_00f0, 1'b0},
    '{OFF_SLAVE_CTRL, 32'hffff_ffff, 4'hf, OFF_SLAVE_CTRL, 32'h0000_0010, 1'b0},
    '{OFF_SLAVE_CTRL, 32'h0000_0000, 4'hf, OFF_SLAVE_CTRL, 32'h0000_0000, 1'b0},
    '{12'h01c, 32'h0000_0055, 4'hf, 12'h01c, 32'h0000_0000, 1'b1}};

  dual_byte_gpio_ports i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portCIn(portCIn), .portCOut(portCOut), .portCOe(portCOe),
    .portDIn(portDIn), .portDOut(portDOut), .portDOe(portDOe),
    .portCPinLevel(portCPinLevel), .portDPinLevel(portDPinLevel), .oscEnable(oscEnable),
    .secondaryOscOut(secondaryOscOut), .timerExtClockEnable(timerExtClockEnable),
    .ccpEnable(ccpEnable), .ccpIsOutput(ccpIsOutput), .ccpOut(ccpOut),
    .sspEnable(sspEnable), .sspClkOe(sspClkOe), .sspClkOut(sspClkOut),
    .sspDataOe(sspDataOe), .sspDataOut(sspDataOut), .sspSdoOut(sspSdoOut),
    .usartEnable(usartEnable), .usartClkTxOe(usartClkTxOe), .usartClkTx(usartClkTx),
    .usartDataOe(usartDataOe), .usartData(usartData),
    .inputBufferFullFlag(inputBufferFullFlag), .outputBufferFullFlag(outputBufferFullFlag),
    .inputOverflowFlag(inputOverflowFlag), .slaveDrive(slaveDrive),
    .slaveDataOut(slaveDataOut),
    .parallelSlaveEnable(parallelSlaveEnable));

  pin_world i_pins (
    .cOut(portCOut), .cOe(portCOe), .dOut(portDOut), .dOe(portDOe),
    .extC(extC), .extD(extD), .cPin(portCIn), .dPin(portDIn));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic fail(string m);
    $display("unexpected at %0t: %s", $time, m);
    n_mismatch++;
  endtask

  task automatic chkReg(logic [31:0] got, logic [31:0] exp, string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  task automatic chkPin(logic [7:0] got, logic [7:0] exp, string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  // One APB transfer; waits on pready with a bound instead of assuming latency
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      fail("no ready");
      report_and_stop();
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hf, r, e);
  endtask

  task automatic expReg(logic [11:0] a, logic [31:0] x, string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    chkReg(r, x, m);
  endtask

  // Apply the peripheral enables and their pin requests together
  task automatic periph(logic [15:0] v);
    @(posedge clk);
    {oscEnable, secondaryOscOut, timerExtClockEnable, ccpEnable, ccpIsOutput, ccpOut,
     sspEnable, sspClkOe, sspClkOut, sspDataOe, sspDataOut, sspSdoOut,
     usartEnable, usartClkTxOe, usartClkTx, usartDataOe} <= v;
    usartData <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  initial begin
    int k;
    logic [31:0] r;
    logic e;
    {psel, penable, pwrite, paddr, pwdata, pstrb, slaveDrive, slaveDataOut} = '0;
    {inputBufferFullFlag, outputBufferFullFlag, inputOverflowFlag} = 3'b000;
    {oscEnable, secondaryOscOut, timerExtClockEnable, ccpEnable, ccpIsOutput, ccpOut} = '0;
    {sspEnable, sspClkOe, sspClkOut, sspDataOe, sspDataOut, sspSdoOut} = '0;
    {usartEnable, usartClkTxOe, usartClkTx, usartDataOe, usartData} = '0;
    extC = 8'h5a;
    extD = 8'h81;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chkPin(portCOe | portDOe, 8'h00, "oe after reset");
    expReg(OFF_C_DIR, 32'h0000_00ff, "c dir reset");
    expReg(OFF_D_DIR, 32'h0000_00ff, "d dir reset");
    expReg(OFF_SLAVE_CTRL, 32'h0000_0000, "ctrl reset");
    for (k = 0; k < 9; k++) begin
      apb(1'b1, rows[k].wa, rows[k].wd, rows[k].st, r, e);
      chkReg({31'h0, e}, {31'h0, rows[k].er}, "write error flag");
      apb(1'b0, rows[k].ra, 32'h0, 4'hf, r, e);
      chkReg(r, rows[k].ex, "readback");
      chkReg({31'h0, e}, {31'h0, rows[k].er}, "read error flag");
    end
    // Mixed direction: latch shows on outputs only, pins read the wire
    repeat (4) @(posedge clk);
    #1;
    chkPin(portCOe, 8'hf0, "c oe");
    chkPin(portCOut & portCOe, 8'ha0, "c out");
    expReg(OFF_C_PIN, 32'h0000_00aa, "c pin read");
    expReg(OFF_C_LAT, 32'h0000_00a5, "c latch read");
    expReg(OFF_D_PIN, 32'h0000_0083, "d pin read");
    chkPin(portCPinLevel, 8'haa, "c level");
    chkPin(portDPinLevel, 8'h83, "d level");
    @(posedge clk);
    extC <= 8'h5f;
    @(posedge clk);
    #1;
    chkPin(portCPinLevel, 8'haa, "sync too fast");
    @(posedge clk);
    #1;
    chkPin(portCPinLevel, 8'haf, "sync late");
    // Peripheral overrides on an all-output port C
    wr(OFF_C_DIR, 32'h0);
    wr(OFF_C_LAT, 32'h0);
    periph(16'hd38f);
    chkPin(portCOe, 8'he9, "override oe a");
    chkPin(portCOut & portCOe, 8'h49, "override out a");
    periph(16'h3f17);
    chkPin(portCOe, 8'hee, "override oe b");
    chkPin(portCOut & portCOe, 8'h24, "override out b");
    expReg(OFF_C_DIR, 32'h0, "dir kept");
    periph(16'h0000);
    // Parallel slave mode takes over port D
    wr(OFF_SLAVE_CTRL, 32'h0000_0010);
    // The enable is launched by the completing edge; look once it has settled
    #1;
    chkPin({7'h0, parallelSlaveEnable}, 8'h01, "slave enable");
    @(posedge clk);
    slaveDrive <= 1'b1;
    slaveDataOut <= 8'h96;
    @(posedge clk);
    #1;
    chkPin(portDOe, 8'hff, "psp oe");
    chkPin(portDOut, 8'h96, "psp data");
    @(posedge clk);
    slaveDrive <= 1'b0;
    {inputBufferFullFlag, outputBufferFullFlag, inputOverflowFlag} <= 3'b111;
    @(posedge clk);
    #1;
    chkPin(portDOe, 8'h00, "psp input");
    expReg(OFF_SLAVE_CTRL, 32'h0000_00f0, "ctrl flags");
    expReg(OFF_D_DIR, 32'h0000_00f0, "d dir kept");
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    {inputBufferFullFlag, outputBufferFullFlag, inputOverflowFlag} <= 3'b000;
    @(posedge clk);
    rst_n <= 1'b1;
    expReg(OFF_C_DIR, 32'h0000_00ff, "c dir rereset");
    expReg(OFF_D_DIR, 32'h0000_00ff, "d dir rereset");
    expReg(OFF_SLAVE_CTRL, 32'h0, "ctrl rereset");
    report_and_stop();
  end
endmodule
`default_nettype wire
